// ===== design/rfx_alu.sv
/*
 * Data unit: result and flags for rotate, fill and subtract-with-borrow.
 * Assumes the caller samples the outputs while the inputs are stable.
 */
`timescale 1ns/1ns
module rfx_alu (
	rfx_alu_if.alu bus
);
	logic [8:0] diff;
	logic [4:0] nib;
	logic       bw;

	// Borrow is the inverted carry
	assign bw   = ~bus.carry_in;
	assign diff = {1'b0, bus.w} - {1'b0, bus.operand} - {8'h00, bw};
	assign nib  = {1'b0, bus.w[3:0]} - {1'b0, bus.operand[3:0]} - {4'h0, bw};

	// Result and flag selection per operation
	always_comb begin
		bus.result = bus.operand;
		bus.flags  = 5'h00;
		bus.upd    = rfx_pkg::UPD_NONE;
		case (bus.op)
			rfx_pkg::OP_RRNC: begin
				bus.result = {bus.operand[0], bus.operand[7:1]};
				bus.flags  = {bus.result[7], 1'b0, bus.result == 8'h00, 2'b00};
				bus.upd    = rfx_pkg::UPD_ROT;
			end
			rfx_pkg::OP_FILL: begin
				bus.result = rfx_pkg::ALL_ONES;
			end
			rfx_pkg::OP_SUBB: begin
				bus.result = diff[7:0];
				// Carry and digit carry mean no borrow out
				bus.flags  = {diff[7],
					(bus.w[7] != bus.operand[7]) && (diff[7] != bus.w[7]),
					diff[7:0] == 8'h00, ~nib[4], ~diff[8]};
				bus.upd    = rfx_pkg::UPD_SUB;
			end
			default: begin
				bus.result = bus.operand;
			end
		endcase
	end
endmodule

// ===== design/rfx_exec_top.sv
/*
 * Executor for rotate-right-no-carry, fill-ones, halt and subtract-with-borrow,
 * with file memory, accumulator, flags, bank select and watchdog, on AXI4-Lite.
 * Assumes one clock, synchronous active-low reset, and a single bus master.
 */
`timescale 1ns/1ns
module rfx_exec_top #(
	parameter int WDT_POST_LIMIT = 128
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             osc_stop
);
	initial begin
		if (WDT_POST_LIMIT < 1 || WDT_POST_LIMIT > 256)
			$error("WDT_POST_LIMIT must lie in 1..256");
	end

	localparam logic [7:0] POST_LAST = 8'(WDT_POST_LIMIT - 1);

	rfx_pkg::rfx_state_t state;
	rfx_pkg::rfx_op_t    op;
	logic [7:0]  mem [0:4095];
	logic        ext_en;
	logic        wdt_en;
	logic [15:0] instr;
	logic [7:0]  wreg;
	logic [4:0]  flags;
	logic        timeout_flag;
	logic        powerdown_flag;
	logic [3:0]  bank_select_reg;
	logic [11:0] index_base;
	logic [11:0] faddr;
	logic [7:0]  wdt_cnt;
	logic [7:0]  wdt_post;
	logic        dest_f;
	logic [11:0] ea;
	logic [7:0]  operand;
	logic [7:0]  result;
	logic [4:0]  res_flags;
	logic [4:0]  res_upd;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_fire;
	logic        busy;
	logic        halt_exec;
	logic        wdt_expire;
	logic        wake_go;
	logic        instr_go;
	logic [31:0] wmerged;
	logic        wr_ok;

	rfx_alu_if alu_bus ();
	rfx_alu u_alu (
		.bus (alu_bus)
	);

	assign alu_bus.op       = op;
	assign alu_bus.operand  = operand;
	assign alu_bus.w        = wreg;
	assign alu_bus.carry_in = flags[rfx_pkg::ST_C_BIT];

	// Opcode decode of the latched instruction word
	function automatic rfx_pkg::rfx_op_t decode_op(input logic [15:0] iw);
		if (iw == rfx_pkg::OPC_HALT)
			return rfx_pkg::OP_HALT;
		else if (iw[15:10] == rfx_pkg::OPC_RRNC)
			return rfx_pkg::OP_RRNC;
		else if (iw[15:10] == rfx_pkg::OPC_SUBB)
			return rfx_pkg::OP_SUBB;
		else if (iw[15:9] == rfx_pkg::OPC_FILL)
			return rfx_pkg::OP_FILL;
		else
			return rfx_pkg::OP_NONE;
	endfunction

	// Effective file address from access bit and 8-bit operand
	function automatic logic [11:0] eff_addr(input logic acc, input logic [7:0] f);
		if (acc)
			return {bank_select_reg, f};
		else if (ext_en && f <= rfx_pkg::LIT_OFS_MAX)
			return index_base + {4'h0, f};
		else if (f < rfx_pkg::ACCESS_SPLIT)
			return {rfx_pkg::ACCESS_LO_BANK, f};
		else
			return {rfx_pkg::ACCESS_HI_BANK, f};
	endfunction

	// Register read mux, also used to merge partial-strobe writes
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == rfx_pkg::OFS_CTRL)
			v = {30'h0, wdt_en, ext_en};
		else if (a == rfx_pkg::OFS_INSTR)
			v = {16'h0000, instr};
		else if (a == rfx_pkg::OFS_WREG)
			v = {24'h00_0000, wreg};
		else if (a == rfx_pkg::OFS_STATUS)
			v = {23'h0, state == rfx_pkg::ST_HALT, busy, powerdown_flag,
				timeout_flag, flags};
		else if (a == rfx_pkg::OFS_BANK)
			v = {28'h000_0000, bank_select_reg};
		else if (a == rfx_pkg::OFS_INDEX)
			v = {20'h0_0000, index_base};
		else if (a == rfx_pkg::OFS_FADDR)
			v = {20'h0_0000, faddr};
		else if (a == rfx_pkg::OFS_FDATA)
			v = {24'h00_0000, mem[faddr]};
		else if (a == rfx_pkg::OFS_WDOG)
			v = {16'h0000, wdt_post, wdt_cnt};
		return v;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a <= rfx_pkg::OFS_WDOG && a[1:0] == 2'b00;
	endfunction

	assign busy       = state != rfx_pkg::ST_IDLE && state != rfx_pkg::ST_HALT;
	assign wr_fire    = !awready && !wready && !bvalid;
	assign wr_ok      = wr_fire && !busy;
	assign halt_exec  = state == rfx_pkg::ST_Q4 && op == rfx_pkg::OP_HALT;
	assign wdt_expire = wdt_en && !halt_exec && wdt_cnt == rfx_pkg::WDT_WRAP
		&& wdt_post == POST_LAST;
	assign instr_go   = wr_fire && aw_addr == rfx_pkg::OFS_INSTR
		&& state == rfx_pkg::ST_IDLE;
	assign wake_go    = wr_fire && aw_addr == rfx_pkg::OFS_WDOG
		&& wmerged[rfx_pkg::WAKE_BIT];

	always_comb begin
		wmerged = rd_mux(aw_addr);
		for (int i = 0; i < 4; i++) begin
			if (w_strb[i])
				wmerged[8*i +: 8] = w_data[8*i +: 8];
		end
	end

	// Write address and data channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= rfx_pkg::RESP_OKAY;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= mapped(aw_addr) ? rfx_pkg::RESP_OKAY : rfx_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Read channel; unmapped reads give zero with an error response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= rfx_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_mux(araddr);
			rresp   <= mapped(araddr) ? rfx_pkg::RESP_OKAY : rfx_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// Phase sequencer; the halt state keeps the oscillator stopped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state    <= rfx_pkg::ST_IDLE;
			osc_stop <= 1'b0;
		end else begin
			case (state)
				rfx_pkg::ST_IDLE: begin
					if (instr_go)
						state <= rfx_pkg::ST_Q1;
				end
				rfx_pkg::ST_Q1: begin
					state <= rfx_pkg::ST_Q2;
				end
				rfx_pkg::ST_Q2: begin
					state <= rfx_pkg::ST_Q3;
				end
				rfx_pkg::ST_Q3: begin
					state <= rfx_pkg::ST_Q4;
				end
				rfx_pkg::ST_Q4: begin
					if (op == rfx_pkg::OP_HALT) begin
						state    <= rfx_pkg::ST_HALT;
						osc_stop <= 1'b1;
					end else begin
						state <= rfx_pkg::ST_IDLE;
					end
				end
				rfx_pkg::ST_HALT: begin
					if (wdt_expire || wake_go) begin
						state    <= rfx_pkg::ST_IDLE;
						osc_stop <= 1'b0;
					end
				end
				default: begin
					state <= rfx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Decode, operand fetch and result capture in phases one to three
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op        <= rfx_pkg::OP_NONE;
			dest_f    <= 1'b1;
			ea        <= 12'h000;
			operand   <= 8'h00;
			result    <= 8'h00;
			res_flags <= 5'h00;
			res_upd   <= 5'h00;
		end else begin
			if (state == rfx_pkg::ST_Q1) begin
				op     <= decode_op(instr);
				// Fill never targets the accumulator, its bit is the access bit
				dest_f <= instr[rfx_pkg::DEST_BIT]
					|| decode_op(instr) == rfx_pkg::OP_FILL;
				ea     <= eff_addr(instr[rfx_pkg::ACC_BIT], instr[7:0]);
			end
			if (state == rfx_pkg::ST_Q2)
				operand <= mem[ea];
			if (state == rfx_pkg::ST_Q3) begin
				result    <= alu_bus.result;
				res_flags <= alu_bus.flags;
				res_upd   <= alu_bus.upd;
			end
		end
	end

	// File memory: write-back in phase four, else the bus data window
	always_ff @(posedge aclk) begin
		if (state == rfx_pkg::ST_Q4 && dest_f && (op == rfx_pkg::OP_RRNC
			|| op == rfx_pkg::OP_SUBB || op == rfx_pkg::OP_FILL))
			mem[ea] <= result;
		else if (wr_ok && aw_addr == rfx_pkg::OFS_FDATA)
			mem[faddr] <= wmerged[7:0];
	end

	// Accumulator, flags and software-owned control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_en          <= 1'b0;
			wdt_en          <= 1'b0;
			instr           <= 16'h0000;
			wreg            <= 8'h00;
			flags           <= 5'h00;
			bank_select_reg <= 4'h0;
			index_base      <= 12'h000;
			faddr           <= 12'h000;
		end else begin
			if (state == rfx_pkg::ST_Q4) begin
				if (!dest_f && (op == rfx_pkg::OP_RRNC || op == rfx_pkg::OP_SUBB))
					wreg <= result;
				// Only flags named by the mask change; fill leaves all alone
				flags <= (flags & ~res_upd) | (res_flags & res_upd);
			end else if (wr_ok) begin
				if (aw_addr == rfx_pkg::OFS_CTRL) begin
					ext_en <= wmerged[rfx_pkg::CTRL_EXT_BIT];
					wdt_en <= wmerged[rfx_pkg::CTRL_WDT_BIT];
				end else if (aw_addr == rfx_pkg::OFS_INSTR && state == rfx_pkg::ST_IDLE)
					instr <= wmerged[15:0];
				else if (aw_addr == rfx_pkg::OFS_WREG)
					wreg <= wmerged[7:0];
				else if (aw_addr == rfx_pkg::OFS_STATUS)
					flags <= wmerged[4:0];
				else if (aw_addr == rfx_pkg::OFS_BANK)
					bank_select_reg <= wmerged[3:0];
				else if (aw_addr == rfx_pkg::OFS_INDEX)
					index_base <= wmerged[11:0];
				else if (aw_addr == rfx_pkg::OFS_FADDR)
					faddr <= wmerged[11:0];
			end
		end
	end

	// Power status flags; halt sets time-out, a watchdog expiry clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_flag   <= rfx_pkg::RST_TO;
			powerdown_flag <= rfx_pkg::RST_PD;
		end else if (halt_exec) begin
			timeout_flag   <= 1'b1;
			powerdown_flag <= 1'b0;
		end else if (wdt_expire) begin
			timeout_flag <= 1'b0;
		end
	end

	// Watchdog keeps counting in halt, since its oscillator is separate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_cnt  <= 8'h00;
			wdt_post <= 8'h00;
		end else if (halt_exec) begin
			wdt_cnt  <= 8'h00;
			wdt_post <= 8'h00;
		end else if (wdt_en) begin
			wdt_cnt <= wdt_cnt + 8'h01;
			if (wdt_cnt == rfx_pkg::WDT_WRAP)
				wdt_post <= (wdt_post == POST_LAST) ? 8'h00 : wdt_post + 8'h01;
		end
	end
endmodule

// ===== include/rfx_alu_if.sv
/*
 * Carrier between the sequencer and the data unit.
 * Assumes both ends run on the same clock; the unit is purely combinational.
 */
`timescale 1ns/1ns
interface rfx_alu_if;
	rfx_pkg::rfx_op_t op;
	logic [7:0]       operand;
	logic [7:0]       w;
	logic             carry_in;
	logic [7:0]       result;
	logic [4:0]       flags;
	logic [4:0]       upd;

	modport core (output op, output operand, output w, output carry_in,
		input result, input flags, input upd);
	modport alu (input op, input operand, input w, input carry_in,
		output result, output flags, output upd);
endinterface

// ===== include/rfx_pkg.sv
/*
 * Shared constants for the rotate/fill/halt/subtract-with-borrow executor:
 * register offsets, field positions, opcode patterns, reset values, states.
 * Assumes it is compiled before every other file of the block.
 */
package rfx_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_INSTR  = 8'h04;
	localparam logic [7:0] OFS_WREG   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_BANK   = 8'h10;
	localparam logic [7:0] OFS_INDEX  = 8'h14;
	localparam logic [7:0] OFS_FADDR  = 8'h18;
	localparam logic [7:0] OFS_FDATA  = 8'h1C;
	localparam logic [7:0] OFS_WDOG   = 8'h20;

	// Field positions
	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_WDT_BIT = 1;
	localparam int ST_C_BIT     = 0;
	localparam int ST_DC_BIT    = 1;
	localparam int ST_Z_BIT     = 2;
	localparam int ST_OV_BIT    = 3;
	localparam int ST_N_BIT     = 4;
	localparam int ST_TO_BIT    = 5;
	localparam int ST_PD_BIT    = 6;
	localparam int ST_BUSY_BIT  = 7;
	localparam int ST_HALT_BIT  = 8;
	localparam int WAKE_BIT     = 0;
	localparam int DEST_BIT     = 9;
	localparam int ACC_BIT      = 8;

	// Opcode patterns
	localparam logic [5:0]  OPC_RRNC = 6'h10;
	localparam logic [5:0]  OPC_SUBB = 6'h15;
	localparam logic [6:0]  OPC_FILL = 7'h34;
	localparam logic [15:0] OPC_HALT = 16'h0003;

	// Addressing constants
	localparam logic [7:0] LIT_OFS_MAX    = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

	// Flag masks, bit order {N, OV, Z, DC, C}, and the fill value
	localparam logic [4:0] UPD_ROT  = 5'h14;
	localparam logic [4:0] UPD_SUB  = 5'h1F;
	localparam logic [4:0] UPD_NONE = 5'h00;
	localparam logic [7:0] ALL_ONES = 8'hFF;

	// Reset values and watchdog wrap count
	localparam logic RST_TO = 1'b1;
	localparam logic RST_PD = 1'b1;
	localparam logic [7:0] WDT_WRAP = 8'hFF;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [4:0] {
		OP_NONE = 5'h01,
		OP_RRNC = 5'h02,
		OP_FILL = 5'h04,
		OP_SUBB = 5'h08,
		OP_HALT = 5'h10
	} rfx_op_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_Q1   = 6'h02,
		ST_Q2   = 6'h04,
		ST_Q3   = 6'h08,
		ST_Q4   = 6'h10,
		ST_HALT = 6'h20
	} rfx_state_t;

endpackage

// ===== test/rfx_exec_checker.sv
/*
 * Checker for rfx_exec_top: bus answer timing, unmapped errors, halt entry and wake.
 * Assumes it is bound to rfx_exec_top and sees only its ports.
 */
`timescale 1ns/1ns
module rfx_exec_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic [7:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        osc_stop
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic       wr_go;
	logic [3:0] since_halt;

	// Both write channels taken in one edge, as the single master offers them
	assign wr_go = awvalid && awready && wvalid && wready;

	// Cycles since a halt word was taken; saturates so stale writes never match
	always_ff @(posedge aclk) begin
		if (!aresetn)
			since_halt <= 4'hF;
		else if (wr_go && awaddr == rfx_pkg::OFS_INSTR && wdata[15:0] == rfx_pkg::OPC_HALT)
			since_halt <= 4'h0;
		else if (since_halt != 4'hF)
			since_halt <= since_halt + 4'h1;
	end

	property p_halt_go;
		wr_go && awaddr == rfx_pkg::OFS_INSTR && wdata[15:0] == rfx_pkg::OPC_HALT && !osc_stop
			|-> ##[3:7] osc_stop;
	endproperty
	a_halt_go: assert property (p_halt_go) else $error("halt did not stop oscillator");
	property p_halt_src;
		$rose(osc_stop) |-> since_halt inside {[4'h3:4'h7]};
	endproperty
	a_halt_src: assert property (p_halt_src) else $error("oscillator stop off phase");
	property p_wake;
		wr_go && awaddr == rfx_pkg::OFS_WDOG && wdata[0] && osc_stop |-> ##[1:3] !osc_stop;
	endproperty
	a_wake: assert property (p_wake) else $error("wake write ignored");
	property p_b_after;
		wr_go |-> ##[1:2] bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write response missing");
	property p_r_after;
		arvalid && arready |=> rvalid;
	endproperty
	a_r_after: assert property (p_r_after) else $error("read response missing");
	property p_bad_wr;
		wr_go && (awaddr[1:0] != 2'h0 || awaddr > rfx_pkg::OFS_WDOG)
			|-> ##[1:2] (bvalid && bresp == rfx_pkg::RESP_SLVERR);
	endproperty
	a_bad_wr: assert property (p_bad_wr) else $error("unmapped write not refused");
	property p_bad_rd;
		arvalid && arready && (araddr[1:0] != 2'h0 || araddr > rfx_pkg::OFS_WDOG)
			|=> rresp == rfx_pkg::RESP_SLVERR && rdata == 32'h0;
	endproperty
	a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
	property p_b_busy;
		bvalid |-> !awready && !wready;
	endproperty
	a_b_busy: assert property (p_b_busy) else $error("write taken before response");
endmodule

bind rfx_exec_top rfx_exec_checker u_rfx_exec_checker (.aclk(aclk), .aresetn(aresetn),
	.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .osc_stop(osc_stop));

// ===== test/tb_rfx_exec_top.sv
/*
 * Testbench for rfx_exec_top: random rotate, fill and subtract, unmapped access, halt, wake.
 * Assumes the register map of rfx_pkg and a postscaler limit of 1.
 */
`timescale 1ns/1ns
module tb_rfx_exec_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, osc_stop;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, seed;
	logic [1:0]  bresp, rresp;
	logic [33:0] exp_q[$];
	int          failures, check_count;

	localparam logic [1:0] OK = rfx_pkg::RESP_OKAY;

	rfx_exec_top #(.WDT_POST_LIMIT(1)) u_rfx_exec_top (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.osc_stop(osc_stop));

	// Eight shifts per byte so successive values are not simple shifts of each other
	function automatic logic [7:0] rnd();
		for (int i = 0; i < 8; i++)
			seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	// Responses are compared in order against the notes left by the drivers
	always @(posedge aclk) begin
		if (bvalid && bready)
			chk("write response", exp_q.size() > 0 ? exp_q.pop_front() : 34'h3, {bresp, 32'h0});
		if (rvalid && rready)
			chk("read response", exp_q.size() > 0 ? exp_q.pop_front() : 34'h3, {rresp, rdata});
	end

	// Waits for the answer however long it takes; only the bench watchdog ends a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask

	// One instruction with random operands, bank, index and addressing bits
	task automatic run_op(input int op);
		logic [7:0]  f, w, fa, res, t;
		logic [11:0] ix, pa;
		logic [15:0] ins;
		logic [8:0]  df;
		logic [4:0]  dn, fl;
		logic        d, a, c, ext, to_file;
		f = rnd();
		w = rnd();
		fa = rnd();
		t = rnd();
		{c, ext, a, d} = t[7:4];
		ix = {t[3:0], rnd()};
		if (a) pa = {t[3:0], fa};
		else if (ext && fa <= rfx_pkg::LIT_OFS_MAX) pa = ix + {4'h0, fa};
		else pa = {fa < rfx_pkg::ACCESS_SPLIT ? 4'h0 : 4'hF, fa};
		df = {1'b0, w} - {1'b0, f} - {8'h0, ~c};
		dn = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, ~c};
		case (op)
			0: res = {f[0], f[7:1]};
			1: res = df[7:0];
			default: res = rfx_pkg::ALL_ONES;
		endcase
		case (op)
			0: fl = {res[7], 1'b0, res == 8'h0, 1'b0, c};
			1: fl = {res[7], (w[7] != f[7]) && (res[7] != w[7]), res == 8'h0, ~dn[4], ~df[8]};
			default: fl = {4'h0, c};
		endcase
		case (op)
			0: ins = {rfx_pkg::OPC_RRNC, d, a, fa};
			1: ins = {rfx_pkg::OPC_SUBB, d, a, fa};
			default: ins = {rfx_pkg::OPC_FILL, a, fa};
		endcase
		to_file = d || op == 2;
		wr(rfx_pkg::OFS_CTRL, {31'h0, ext}, OK);
		wr(rfx_pkg::OFS_BANK, {28'h0, t[3:0]}, OK);
		wr(rfx_pkg::OFS_INDEX, {20'h0, ix}, OK);
		wr(rfx_pkg::OFS_WREG, {24'h0, w}, OK);
		wr(rfx_pkg::OFS_STATUS, {31'h0, c}, OK);
		wr(rfx_pkg::OFS_FADDR, {20'h0, pa}, OK);
		wr(rfx_pkg::OFS_FDATA, {24'h0, f}, OK);
		wr(rfx_pkg::OFS_INSTR, {16'h0, ins}, OK);
		repeat (6) @(posedge aclk);
		rd(rfx_pkg::OFS_FDATA, {OK, 24'h0, to_file ? res : f});
		rd(rfx_pkg::OFS_WREG, {OK, 24'h0, to_file ? w : res});
		rd(rfx_pkg::OFS_STATUS, {OK, 23'h0, 4'h3, fl});
	endtask

	task automatic end_of_test();
		repeat (2) @(posedge aclk);
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Free-running bench clock, 8 ns period
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// Cuts a hang short well beyond the fewer than two thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		$display("run limit reached");
		end_of_test();
	end

	// Main sequence
	initial begin
		int n;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata} = 48'h0;
		{seed, failures, check_count} = {32'hE10E, 64'h0};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(rfx_pkg::OFS_STATUS, {OK, 32'h60});
		for (int i = 0; i < 24; i++)
			run_op(i % 3);
		$display("test operations done");
		wr(8'h24, 32'h1, rfx_pkg::RESP_SLVERR);
		rd(8'h22, {rfx_pkg::RESP_SLVERR, 32'h0});
		$display("test unmapped done");
		wr(rfx_pkg::OFS_STATUS, 32'h0, OK);
		wr(rfx_pkg::OFS_CTRL, 32'h0, OK);
		wr(rfx_pkg::OFS_INSTR, {16'h0, rfx_pkg::OPC_HALT}, OK);
		repeat (6) @(posedge aclk);
		chk("osc_stop", 34'h1, {33'h0, osc_stop});
		rd(rfx_pkg::OFS_STATUS, {OK, 32'h120});
		rd(rfx_pkg::OFS_WDOG, {OK, 32'h0});
		wr(rfx_pkg::OFS_WDOG, 32'h1, OK);
		rd(rfx_pkg::OFS_STATUS, {OK, 32'h20});
		$display("test halt done");
		wr(rfx_pkg::OFS_CTRL, 32'h2, OK);
		repeat (9'd40 + {1'b0, rnd()}) @(posedge aclk);
		wr(rfx_pkg::OFS_INSTR, {16'h0, rfx_pkg::OPC_HALT}, OK);
		n = 0;
		while (!osc_stop && n < 20) begin
			@(posedge aclk);
			n++;
		end
		n = 0;
		while (osc_stop && n < 1000) begin
			@(posedge aclk);
			n++;
		end
		chk("wake cycles", 34'h1, {33'h0, n >= 250 && n <= 262});
		rd(rfx_pkg::OFS_STATUS, {OK, 32'h0});
		$display("test watchdog wake done");
		end_of_test();
	end
endmodule
